// ==== rtl/rdb_cell_addr.sv ====
// Word address of the cell currently being written
`default_nettype none
`include "rdb_params.svh"
module rdb_cell_addr
    import rdb_pkg::*;
#(
    parameter int ADDR_W = 20
) (
    // Clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // Buffer placement
    input  wire logic [10:0]       base_upper,
    input  wire logic [6:0]        write_ptr,
    // Result
    output logic [ADDR_W-1:0]      cell_addr
);
    // ==========================================================
    // Address composition
    // Base fills the upper bits, low nine bits forced to zero
    wire [ADDR_W-1:0] base_word = ADDR_W'({base_upper,
                                  `RDB_BASE_SHIFT'(0)});
    // Each cell spans 32 words
    wire [ADDR_W-1:0] cell_off  = ADDR_W'({write_ptr,
                                  `RDB_CELL_SHIFT'(0)});
    // Sum, not OR, so a misaligned base still yields a defined address
    wire [ADDR_W-1:0] next_addr = base_word + cell_off;

    // Registered output
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cell_addr <= '0;
        end else begin
            cell_addr <= next_addr;
        end
    end
endmodule : rdb_cell_addr
`default_nettype wire

// ==== rtl/rdb_params.svh ====
// Constants for the receive data cell buffer pointer block
`ifndef RDB_PARAMS_SVH
`define RDB_PARAMS_SVH
// Register indices; byte address is four times the index
`define RDB_IDX_CTRL      16'h2020
`define RDB_IDX_STATUS    16'h2022
`define RDB_IDX_CONFIG    16'h2024
`define RDB_IDX_WR_PTR    16'h2026
`define RDB_IDX_RD_PTR    16'h2028
`define RDB_IDX_COUNT     16'h202A
`define RDB_IDX_MASK      16'h2030
// Reset values
`define RDB_RST_WR_PTR    7'h00
`define RDB_RST_RD_PTR    7'h7F
`define RDB_RST_COUNT     16'h0000
`define RDB_RST_CONFIG    13'h0000
// Field positions
`define RDB_CTRL_ENB      0
`define RDB_CFG_SIZE_LO   0
`define RDB_CFG_SIZE_HI   1
`define RDB_CFG_BASE_LO   2
`define RDB_CFG_BASE_HI   12
`define RDB_ST_OVERRUN    1
`define RDB_ST_ARRIVAL    2
`define RDB_ST_ROLLOVER   4
// Smallest buffer and words per cell
`define RDB_MIN_CELLS     8'h10
`define RDB_CELL_SHIFT    5
`define RDB_BASE_SHIFT    9
`define RDB_COUNT_MAX     16'hFFFF
`endif

// ==== rtl/rdb_pkg.sv ====
// Types shared by the receive data cell buffer pointer block
`default_nettype none
package rdb_pkg;
    // Latched AHB address phase
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] idx;
    } rdb_ahb_req_t;
    // Sticky event flags
    typedef struct packed {
        logic rollover;
        logic arrival;
        logic overrun;
    } rdb_flags_t;
endpackage : rdb_pkg
`default_nettype wire

// ==== rtl/rdb_top.sv ====
// Receive data cell buffer pointers, counter and AHB-Lite registers
// ==========================================================
// Overview of operation
// - Size selector 00..11 gives 16, 32, 64 or 128 cells.
// - Base field config bits 12:2 gives address bits 19:9; 8:0 zero.
// - Cell address is base plus index times 32 words.
// - Read-only write pointer names cell in progress; steps per write.
// - Write pointer stays below the configured cell count, except between a size shrink and the next cell.
// - Write pointer cleared at reset and whenever enable is clear.
// - Software-owned read pointer; hardware never moves it.
// - Read pointer resets to 7Fh, the last cell of a 128-cell buffer.
// - Sixteen-bit read-only count of received cells.
// - While disabled, cells ignored and write pointer held at zero.
// - Sticky overrun flag when write pointer equals read pointer while enabled.
// - Sticky arrival flag per written cell; cleared by writing zero.
// - Sticky rollover flag on count overflow; cleared by writing zero.
//
// Local design decision: the AHB-Lite register port.
`default_nettype none
`include "rdb_params.svh"
module rdb_top
    import rdb_pkg::*;
#(
    parameter int ADDR_W = 20
) (
    // Clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [31:0]       hwdata,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Receive path
    input  wire logic              cell_done,
    output logic [ADDR_W-1:0]      cell_addr,
    output logic                   rx_data_path_enable,
    // Interrupt
    output logic                   irq
);
    // ==========================================================
    // Registers
    logic [6:0]   cell_write_ptr;
    logic [6:0]   cell_read_ptr;
    logic [15:0]  cell_count;
    logic [1:0]   buffer_size_sel;
    logic [10:0]  buffer_base_upper;
    rdb_flags_t   flags;
    rdb_flags_t   irq_mask;
    rdb_ahb_req_t req;

    // ==========================================================
    // Bus decode
    // Non-sequential and sequential word transfers are claimed
    wire        addr_ok  = (haddr[31:18] == 14'h0000) &&
                           (haddr[1:0] == 2'h0);
    wire        take     = hsel && hready && htrans[1];
    wire [15:0] take_idx = haddr[17:2];
    wire        wr_now   = req.valid && req.write;
    wire        wr_ctrl  = wr_now && (req.idx == `RDB_IDX_CTRL);
    wire        wr_stat  = wr_now && (req.idx == `RDB_IDX_STATUS);
    wire        wr_cfg   = wr_now && (req.idx == `RDB_IDX_CONFIG);
    wire        wr_rdptr = wr_now && (req.idx == `RDB_IDX_RD_PTR);
    wire        wr_mask  = wr_now && (req.idx == `RDB_IDX_MASK);

    // Registers answer with no wait state and never an error
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Address phase capture; hsize is not checked, word only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req <= '0;
        end else if (hready) begin
            req.valid <= take && addr_ok;
            req.write <= hwrite;
            req.idx   <= take_idx;
        end
    end

    // ==========================================================
    // Status and read mux
    wire [15:0] status_word = 16'({flags.rollover, 1'b0, flags.arrival,
                                   flags.overrun, 1'b0});
    wire [15:0] mask_word   = 16'({irq_mask.rollover, 1'b0,
                                   irq_mask.arrival, irq_mask.overrun,
                                   1'b0});
    wire [15:0] cfg_word    = 16'({buffer_base_upper, buffer_size_sel});
    wire [15:0] ctrl_word   = 16'(rx_data_path_enable);
    logic [15:0] next_rdata;

    // Reserved bits and unmapped indices read as zero
    always_comb begin
        next_rdata = 16'h0000;
        unique case (take_idx)
            `RDB_IDX_CTRL:   next_rdata = ctrl_word;
            `RDB_IDX_STATUS: next_rdata = status_word;
            `RDB_IDX_CONFIG: next_rdata = cfg_word;
            `RDB_IDX_WR_PTR: next_rdata = 16'(cell_write_ptr);
            `RDB_IDX_RD_PTR: next_rdata = 16'(cell_read_ptr);
            `RDB_IDX_COUNT:  next_rdata = cell_count;
            `RDB_IDX_MASK:   next_rdata = mask_word;
            default:         next_rdata = 16'h0000;
        endcase
    end

    // Read data is sampled in the address phase, held for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata <= addr_ok ? 32'(next_rdata) : 32'h0000_0000;
        end
    end

    // ==========================================================
    // Control, configuration and mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_data_path_enable <= 1'b0;
            buffer_size_sel     <= 2'h0;
            buffer_base_upper   <= 11'h000;
            irq_mask            <= '0;
        end else begin
            if (wr_ctrl)
                rx_data_path_enable <= hwdata[`RDB_CTRL_ENB];
            if (wr_cfg) begin
                buffer_size_sel   <= hwdata[`RDB_CFG_SIZE_HI:
                                            `RDB_CFG_SIZE_LO];
                buffer_base_upper <= hwdata[`RDB_CFG_BASE_HI:
                                            `RDB_CFG_BASE_LO];
            end
            if (wr_mask) begin
                irq_mask.overrun  <= hwdata[`RDB_ST_OVERRUN];
                irq_mask.arrival  <= hwdata[`RDB_ST_ARRIVAL];
                irq_mask.rollover <= hwdata[`RDB_ST_ROLLOVER];
            end
        end
    end

    // ==========================================================
    // Write pointer
    // Capacity 16 shifted by the selector, minus one, is the top index
    wire [7:0] size_cells = 8'(`RDB_MIN_CELLS << buffer_size_sel);
    wire [6:0] top_index  = 7'(size_cells - 8'h01);
    wire       cell_ok    = cell_done && rx_data_path_enable;
    wire       at_top     = ((cell_write_ptr & top_index) == top_index);
    // Masking returns the pointer to range on the next cell if size shrinks mid-run
    wire [6:0] next_wp    = at_top ? `RDB_RST_WR_PTR
                          : 7'((cell_write_ptr & top_index) + 7'h01);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cell_write_ptr <= `RDB_RST_WR_PTR;
        end else if (!rx_data_path_enable) begin
            cell_write_ptr <= `RDB_RST_WR_PTR;
        end else if (cell_ok) begin
            cell_write_ptr <= next_wp;
        end
    end

    // ==========================================================
    // Read pointer, moved only by software
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cell_read_ptr <= `RDB_RST_RD_PTR;
        end else if (wr_rdptr) begin
            cell_read_ptr <= hwdata[6:0];
        end
    end

    // ==========================================================
    // Received cell counter, wraps naturally
    wire count_wrap = cell_ok && (cell_count == `RDB_COUNT_MAX);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cell_count <= `RDB_RST_COUNT;
        end else if (cell_ok) begin
            cell_count <= cell_count + 16'h0001;
        end
    end

    // ==========================================================
    // Sticky flags: a set in the same cycle as a clear wins
    wire set_over = rx_data_path_enable &&
                    (cell_write_ptr == cell_read_ptr);
    wire clr_over = wr_stat && !hwdata[`RDB_ST_OVERRUN];
    wire clr_arr  = wr_stat && !hwdata[`RDB_ST_ARRIVAL];
    wire clr_roll = wr_stat && !hwdata[`RDB_ST_ROLLOVER];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags <= '0;
        end else begin
            flags.overrun  <= set_over   || (flags.overrun  && !clr_over);
            flags.arrival  <= cell_ok ||
                              (flags.arrival && !clr_arr);
            flags.rollover <= count_wrap ||
                              (flags.rollover && !clr_roll);
        end
    end

    // Level interrupt from unmasked flags
    assign irq = |(flags & irq_mask);

    // ==========================================================
    // Cell address generation
    rdb_cell_addr #(
        .ADDR_W     (ADDR_W)
    ) u_cell_addr (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .base_upper (buffer_base_upper),
        .write_ptr  (cell_write_ptr),
        .cell_addr  (cell_addr)
    );

    // ==========================================================
    // Assertions
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_wp_range: assert property (
        cell_write_ptr <= top_index)
        else $error("write pointer beyond buffer size");

    chk_wp_wrap: assert property (
        (cell_ok && cell_write_ptr == top_index && !wr_cfg)
        |=> cell_write_ptr == 7'h00)
        else $error("write pointer did not wrap to zero");

    chk_wp_step: assert property (
        (cell_ok && cell_write_ptr < top_index && !wr_cfg && !wr_ctrl)
        |=> cell_write_ptr == $past(cell_write_ptr) + 7'h01)
        else $error("write pointer did not step by one");

    chk_wp_disabled: assert property (
        !rx_data_path_enable |=> cell_write_ptr == 7'h00)
        else $error("write pointer not held at zero while disabled");

    chk_rp_owned: assert property (
        !wr_rdptr |=> $stable(cell_read_ptr))
        else $error("read pointer moved without a software write");

    chk_count_step: assert property (
        cell_ok |=> cell_count == $past(cell_count) + 16'h0001)
        else $error("cell counter did not increment");

    chk_count_idle: assert property (
        !cell_ok |=> $stable(cell_count))
        else $error("cell counter moved without a cell");

    chk_roll_set: assert property (
        count_wrap |=> cell_count == 16'h0000 && flags.rollover)
        else $error("counter rollover mishandled");

    chk_arrival_set: assert property (
        cell_ok |=> flags.arrival)
        else $error("arrival flag not set after a cell");

    chk_overrun_set: assert property (
        set_over |=> flags.overrun)
        else $error("overrun flag not set on pointer match");

    chk_cell_addr: assert property (
        ##1 cell_addr == ADDR_W'({$past(buffer_base_upper), 9'h000})
                       + ADDR_W'({$past(cell_write_ptr), 5'h00}))
        else $error("cell address not base plus index times 32");

    chk_irq_level: assert property (
        irq == |(flags & irq_mask))
        else $error("interrupt does not follow masked flags");

    cov_wrap:    cover property (cell_ok && at_top);
    cov_overrun: cover property (set_over && !flags.overrun);
    cov_roll:    cover property (count_wrap);
    cov_clear:   cover property (clr_arr && cell_ok);
endmodule : rdb_top
`default_nettype wire

// ==== verif/rdb_host_model.sv ====
// Host processor model: AHB-Lite master for register traffic
`default_nettype none
module rdb_host_model (
    // Clock
    input  wire logic        hclk,
    // AHB-Lite master side
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Idle bus; data lines never keep a stale value
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'hA5A5_A5A5;
    end

    // Address phase held until hready, then back to IDLE
    task automatic addr_phase(input logic [31:0] a, input logic wr);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        haddr  <= ~a;
    endtask : addr_phase

    // Single word write
    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        addr_phase(a, 1'b1);
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        hwdata <= ~d;
    endtask : bus_wr

    // Single word read, data taken at the edge ending the data phase
    task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
        addr_phase(a, 1'b0);
        do @(posedge hclk); while (hready !== 1'b1);
        d = hrdata;
    endtask : bus_rd
endmodule : rdb_host_model
`default_nettype wire

// ==== verif/tb_rx_data_cell_buffer_pointers.sv ====
// Self-checking testbench for the receive cell buffer pointer block
`default_nettype none
`include "rdb_params.svh"
module tb_rx_data_cell_buffer_pointers;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Signals
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        cell_done, rx_data_path_enable, irq;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd, cfg, bw;
    logic [19:0] cell_addr;
    logic [10:0] bases [4];
    int          fail_count, n_tests, exp_cnt, cycles, n;

    // Byte address of a register index
    function automatic logic [31:0] ba(input logic [15:0] idx);
        return {14'h0, idx, 2'b00};
    endfunction : ba

    rdb_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cell_done(cell_done),
        .cell_addr(cell_addr), .rx_data_path_enable(rx_data_path_enable),
        .irq(irq));
    rdb_host_model host (.hclk(hclk), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

    // ==========================================================
    // Clock, and a cycle ceiling well above the rollover burst
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            give_verdict();
        end
    end

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Register read by index, compared against an expected word
    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
        host.bus_rd(ba(idx), rd);
        check(rd, exp);
    endtask : rd_chk

    // Register write by index
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        host.bus_wr(ba(idx), d);
    endtask : wr

    // Back-to-back cell completions, one per cycle
    task automatic cells(input int k);
        @(posedge hclk);
        cell_done <= 1'b1;
        repeat (k) @(posedge hclk);
        cell_done <= 1'b0;
    endtask : cells

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    // ==========================================================
    // Main sequence; pins launched at an edge are looked at a half
    // period later, once the register outputs have settled
    initial begin
        bases = '{11'h7FF, 11'h2A2, 11'h154, 11'h408};
        cell_done = 1'b0;
        exp_cnt = 0;
        hresetn = 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values: disabled, no interrupt, bus never waits or errs
        @(negedge hclk);
        check({28'h0, irq, rx_data_path_enable, hresp, hreadyout},
              32'h1);
        rd_chk(`RDB_IDX_WR_PTR, 32'h0);
        rd_chk(`RDB_IDX_RD_PTR, 32'h7F);
        rd_chk(`RDB_IDX_COUNT, 32'h0);
        rd_chk(`RDB_IDX_CONFIG, 32'h0);
        // Read-only places ignore writes; bit 18 set is unmapped
        wr(`RDB_IDX_WR_PTR, 32'h55);
        rd_chk(`RDB_IDX_WR_PTR, 32'h0);
        wr(`RDB_IDX_COUNT, 32'h1234);
        rd_chk(`RDB_IDX_COUNT, 32'h0);
        host.bus_rd(32'h0004_80A0, rd);
        check(rd, 32'h0);
        // Read pointer keeps only its seven bits
        wr(`RDB_IDX_RD_PTR, 32'hFF85);
        rd_chk(`RDB_IDX_RD_PTR, 32'h05);
        // Host moves the pointer to the first cell before reading it
        wr(`RDB_IDX_RD_PTR, 32'h0);
        // Every size: fill to the top index, wrap, then disable
        for (int s = 0; s < 4; s++) begin
            n = 16 << s;
            cfg = {19'h0, bases[s], 2'(s)};
            bw = {12'h0, bases[s], 9'h000};
            wr(`RDB_IDX_CONFIG, cfg);
            rd_chk(`RDB_IDX_CONFIG, cfg);
            wr(`RDB_IDX_CTRL, 32'h1);
            @(negedge hclk);
            check({31'h0, rx_data_path_enable}, 32'h1);
            cells(n - 1);
            rd_chk(`RDB_IDX_WR_PTR, 32'(n - 1));
            check({12'h0, cell_addr}, bw + 32'((n - 1) * 32));
            cells(1);
            rd_chk(`RDB_IDX_WR_PTR, 32'h0);
            check({12'h0, cell_addr}, bw);
            cells(3);
            exp_cnt += n + 3;
            rd_chk(`RDB_IDX_WR_PTR, 32'h3);
            // Pointer left on the last cell read; hardware must not move it
            rd_chk(`RDB_IDX_RD_PTR, 32'h0);
            wr(`RDB_IDX_CTRL, 32'h0);
            rd_chk(`RDB_IDX_WR_PTR, 32'h0);
            cells(2);
            rd_chk(`RDB_IDX_WR_PTR, 32'h0);
            rd_chk(`RDB_IDX_COUNT, 32'(exp_cnt));
        end
        // Flags: overrun from equal pointers, arrival per cell
        rd_chk(`RDB_IDX_STATUS, 32'h6);
        check({31'h0, irq}, 32'h0);
        wr(`RDB_IDX_MASK, 32'h4);
        @(negedge hclk);
        check({31'h0, irq}, 32'h1);
        rd_chk(`RDB_IDX_MASK, 32'h4);
        wr(`RDB_IDX_STATUS, 32'hFFFB);
        rd_chk(`RDB_IDX_STATUS, 32'h2);
        check({31'h0, irq}, 32'h0);
        wr(`RDB_IDX_STATUS, 32'h0);
        rd_chk(`RDB_IDX_STATUS, 32'h0);
        // Counter overflow: burst up to the wrap point
        wr(`RDB_IDX_MASK, 32'h10);
        wr(`RDB_IDX_CTRL, 32'h1);
        cells(65536 - exp_cnt);
        rd_chk(`RDB_IDX_COUNT, 32'h0);
        host.bus_rd(ba(`RDB_IDX_STATUS), rd);
        check(rd & 32'h10, 32'h10);
        check({31'h0, irq}, 32'h1);
        wr(`RDB_IDX_STATUS, 32'hFFEF);
        @(negedge hclk);
        check({31'h0, irq}, 32'h0);
        give_verdict();
    end
endmodule : tb_rx_data_cell_buffer_pointers
`default_nettype wire
